/* File: src/highv_input_port_control.sv */
`timescale 1ns/100ps
`include "highv_regs.svh"
module highv_input_port_control (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire highv_pkg::addr_t    addr,
  input  wire highv_pkg::data_t    wrData,
  input  wire logic                wrEn,
  input  wire logic                rdEn,
  output      highv_pkg::data_t    rdData,
  input  wire highv_pkg::pin_vec_t high_voltage_input_pin,
  input  wire highv_pkg::pin_vec_t highv_digital_input_enable,
  input  wire highv_pkg::pin_vec_t highv_adc_connect_enable,
  input  wire highv_pkg::pin_vec_t highv_test_enable,
  input  wire logic                stopMode,
  output      highv_pkg::pin_vec_t inputBufferEnable,
  output      highv_pkg::pin_vec_t pullupEnable,
  output      highv_pkg::pin_vec_t pulldownEnable,
  output      highv_pkg::pin_vec_t dividerActive,
  output      highv_pkg::pin_vec_t adcDirectPath,
  output      highv_pkg::pin_vec_t converterBypass,
  output      logic                irq
);
  highv_pkg::pin_vec_t highv_pull_select;
  highv_pkg::pin_vec_t highv_edge_polarity;
  highv_pkg::pin_vec_t highv_converter_bypass;
  highv_pkg::pin_vec_t highv_direct_connect;
  highv_pkg::pin_vec_t eventStatus;
  highv_pkg::pin_vec_t eventMask;
  highv_pkg::pin_vec_t digitalMode;
  highv_pkg::pin_vec_t stateView;
  highv_pkg::pin_vec_t next_bufEn;
  highv_pkg::pin_vec_t next_pullup;
  highv_pkg::reg_sel_e wrSel;
  highv_pkg::reg_sel_e rdSel;
  highv_pkg::data_t    next_rdData;

  // ------------------------------------------------------------
  // Address decode, shared by write and read paths
  // ------------------------------------------------------------
  function automatic highv_pkg::reg_sel_e decode(highv_pkg::addr_t a);
    highv_pkg::reg_sel_e s;
    s = highv_pkg::SEL_NONE;
    unique case (a)
      `HIGHV_OFS_INPUT_STATE:    s = highv_pkg::SEL_INPUT_STATE;
      `HIGHV_OFS_PULL_SELECT:    s = highv_pkg::SEL_PULL_SELECT;
      `HIGHV_OFS_EDGE_POLARITY:  s = highv_pkg::SEL_EDGE_POLARITY;
      `HIGHV_OFS_CONV_BYPASS:    s = highv_pkg::SEL_CONV_BYPASS;
      `HIGHV_OFS_DIRECT_CONNECT: s = highv_pkg::SEL_DIRECT_CONNECT;
      `HIGHV_OFS_EVENT_STATUS:   s = highv_pkg::SEL_EVENT_STATUS;
      `HIGHV_OFS_EVENT_MASK:     s = highv_pkg::SEL_EVENT_MASK;
      default:                   s = highv_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  assign wrSel = wrEn ? decode(addr) : highv_pkg::SEL_NONE;
  assign rdSel = decode(addr);

  // ------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ------------------------------------------------------------
  highv_sync_if syncBus ();

  assign syncBus.pinRaw   = high_voltage_input_pin;
  assign syncBus.polarity = highv_edge_polarity;

  highv_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port    (syncBus.sync)
  );

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // The input state has no storage; a write there lands nowhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      highv_pull_select <= `HIGHV_CFG_RESET;
    end else if (wrSel == highv_pkg::SEL_PULL_SELECT) begin
      highv_pull_select <= wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      highv_edge_polarity <= `HIGHV_CFG_RESET;
    end else if (wrSel == highv_pkg::SEL_EDGE_POLARITY) begin
      highv_edge_polarity <= wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      highv_converter_bypass <= `HIGHV_CFG_RESET;
    end else if (wrSel == highv_pkg::SEL_CONV_BYPASS) begin
      highv_converter_bypass <= wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      highv_direct_connect <= `HIGHV_CFG_RESET;
    end else if (wrSel == highv_pkg::SEL_DIRECT_CONNECT) begin
      highv_direct_connect <= wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB];
    end
  end

  // ------------------------------------------------------------
  // Event status, mask and interrupt
  // ------------------------------------------------------------
  // Set beats the write-one clear so no edge is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eventStatus <= `HIGHV_CFG_RESET;
    end else begin
      eventStatus <= (eventStatus &
                      ~((wrSel == highv_pkg::SEL_EVENT_STATUS) ?
                        wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB] :
                        `HIGHV_CFG_RESET))
                     | (syncBus.edgeEvent & digitalMode);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eventMask <= `HIGHV_CFG_RESET;
    end else if (wrSel == highv_pkg::SEL_EVENT_MASK) begin
      eventMask <= wrData[`HIGHV_PIN_MSB:`HIGHV_PIN_LSB];
    end
  end

  // Straight from a flop, so irq lags status by one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventMask & eventStatus);
    end
  end

  // ------------------------------------------------------------
  // Pad and analog path control
  // ------------------------------------------------------------
  assign digitalMode = highv_digital_input_enable &
                       ~highv_adc_connect_enable;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (stopMode) begin
        next_bufEn[i] = highv_digital_input_enable[i];
      end else if (highv_adc_connect_enable[i]) begin
        next_bufEn[i] = highv_test_enable[i] &
                        ~highv_direct_connect[i];
      end else begin
        next_bufEn[i] = highv_digital_input_enable[i];
      end
    end
  end

  assign next_pullup = highv_adc_connect_enable & highv_pull_select &
                       highv_test_enable & {2{~stopMode}};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inputBufferEnable <= `HIGHV_CFG_RESET;
      pullupEnable      <= `HIGHV_CFG_RESET;
      pulldownEnable    <= `HIGHV_CFG_RESET;
    end else begin
      inputBufferEnable <= next_bufEn;
      pullupEnable      <= next_pullup;
      pulldownEnable    <= highv_adc_connect_enable &
                           ~next_pullup;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dividerActive   <= `HIGHV_CFG_RESET;
      adcDirectPath   <= `HIGHV_CFG_RESET;
      converterBypass <= `HIGHV_CFG_RESET;
    end else begin
      dividerActive   <= highv_adc_connect_enable &
                         ~highv_direct_connect;
      adcDirectPath   <= highv_adc_connect_enable &
                         highv_direct_connect;
      converterBypass <= highv_adc_connect_enable &
                         highv_direct_connect &
                         highv_converter_bypass;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Non-digital pins read as one
  assign stateView = (syncBus.pinSync & digitalMode) |
                     ~digitalMode;

  always_comb begin
    next_rdData = `HIGHV_RD_IDLE;
    unique case (rdSel)
      highv_pkg::SEL_INPUT_STATE:    next_rdData[1:0] = stateView;
      highv_pkg::SEL_PULL_SELECT:    next_rdData[1:0] = highv_pull_select;
      highv_pkg::SEL_EDGE_POLARITY:  next_rdData[1:0] = highv_edge_polarity;
      highv_pkg::SEL_CONV_BYPASS:
        next_rdData[1:0] = highv_converter_bypass;
      highv_pkg::SEL_DIRECT_CONNECT: next_rdData[1:0] = highv_direct_connect;
      highv_pkg::SEL_EVENT_STATUS:   next_rdData[1:0] = eventStatus;
      highv_pkg::SEL_EVENT_MASK:     next_rdData[1:0] = eventMask;
      highv_pkg::SEL_NONE:           next_rdData = `HIGHV_RD_IDLE;
    endcase
  end

  // Data stand for one cycle only; upper bits stay zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= `HIGHV_RD_IDLE;
    end else if (rdEn) begin
      rdData <= next_rdData;
    end else begin
      rdData <= `HIGHV_RD_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_stateDigital;
    rdEn && addr == `HIGHV_OFS_INPUT_STATE && digitalMode[0]
      |=> rdData[0] == $past(syncBus.pinSync[0]);
  endproperty
  a_stateDigital: assert property (p_stateDigital)
    else $error("digital pin state not returned");

  property p_stateOther;
    rdEn && addr == `HIGHV_OFS_INPUT_STATE && !digitalMode[1]
      |=> rdData[1];
  endproperty
  a_stateOther: assert property (p_stateOther)
    else $error("non-digital pin did not read one");

  property p_stateNoWrite;
    wrEn && addr == `HIGHV_OFS_INPUT_STATE
      |=> $stable(highv_pull_select) && $stable(highv_edge_polarity)
          && $stable(highv_converter_bypass)
          && $stable(highv_direct_connect) && $stable(eventMask);
  endproperty
  a_stateNoWrite: assert property (p_stateNoWrite)
    else $error("write to input state changed a register");

  property p_pulldown;
    highv_adc_connect_enable[0] && !highv_pull_select[0]
      |=> pulldownEnable[0] && !pullupEnable[0];
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pulldown not kept in analog mode");

  property p_pullup;
    pullupEnable[1] |-> $past(highv_pull_select[1])
      && $past(highv_test_enable[1]) && !$past(stopMode)
      && !pulldownEnable[1];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pullup without its conditions");

  property p_edgeSet;
    syncBus.edgeEvent[0] && digitalMode[0]
      |=> eventStatus[0] ##1 (irq || !$past(eventMask[0]));
  endproperty
  a_edgeSet: assert property (p_edgeSet)
    else $error("selected edge did not set status");

  property p_bypass;
    converterBypass[0] |-> $past(highv_direct_connect[0])
      && $past(highv_converter_bypass[0])
      && $past(highv_adc_connect_enable[0]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("converter bypassed without direct path");

  property p_direct;
    highv_adc_connect_enable[1] && highv_direct_connect[1]
      |=> adcDirectPath[1] && !dividerActive[1];
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct path not routed");

  property p_directQual;
    !highv_adc_connect_enable[0] |=> !adcDirectPath[0]
      && !dividerActive[0] && !converterBypass[0];
  endproperty
  a_directQual: assert property (p_directQual)
    else $error("direct connection acted outside analog mode");

  property p_stopBuf;
    stopMode |=> inputBufferEnable == $past(highv_digital_input_enable);
  endproperty
  a_stopBuf: assert property (p_stopBuf)
    else $error("buffer not following enable in stop mode");

  property p_analogRun;
    !stopMode && highv_adc_connect_enable[1] && !highv_test_enable[1]
      |=> !inputBufferEnable[1];
  endproperty
  a_analogRun: assert property (p_analogRun)
    else $error("buffer left on in analog run mode");

  property p_upperZero;
    rdData[7:2] == 6'h00;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("unimplemented read bits not zero");

  property p_idleRead;
    !rdEn |=> rdData == 8'h00;
  endproperty
  a_idleRead: assert property (p_idleRead)
    else $error("read data not zero outside a read");

  // Converter control must stay off while the bypass bit is clear
  property p_bypassOff;
    !highv_converter_bypass[1] |=> !converterBypass[1];
  endproperty
  a_bypassOff: assert property (p_bypassOff)
    else $error("converter bypassed with bypass bit clear");

  property p_irqLevel;
    irq == $past(|(eventMask & eventStatus));
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("irq not following masked status");

  // Status is sticky until software writes a one
  property p_statusSticky;
    eventStatus[1]
      && !(wrSel == highv_pkg::SEL_EVENT_STATUS && wrData[1])
      |=> eventStatus[1];
  endproperty
  a_statusSticky: assert property (p_statusSticky)
    else $error("event status dropped without a clear");

  c_readState:  cover property (rdEn && rdSel == highv_pkg::SEL_INPUT_STATE
                                ##1 rdData[0]);
  c_edgeIrq:    cover property (syncBus.edgeEvent[0] ##[1:3] irq);
  c_pullup:     cover property (pullupEnable[0]);
  c_bypass:     cover property (converterBypass[1]);
endmodule

/* File: src/highv_regs.svh */
`ifndef HIGHV_REGS_SVH
`define HIGHV_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define HIGHV_OFS_INPUT_STATE    16'h0331
`define HIGHV_OFS_PULL_SELECT    16'h0332
`define HIGHV_OFS_EDGE_POLARITY  16'h0333
`define HIGHV_OFS_CONV_BYPASS    16'h0334
`define HIGHV_OFS_DIRECT_CONNECT 16'h033B
`define HIGHV_OFS_EVENT_STATUS   16'h0340
`define HIGHV_OFS_EVENT_MASK     16'h0341

// ------------------------------------------------------------
// Field layout and reset values
// ------------------------------------------------------------
`define HIGHV_PIN_MSB            1
`define HIGHV_PIN_LSB            0
`define HIGHV_CFG_RESET          2'h0
`define HIGHV_RD_IDLE            8'h00
`define HIGHV_SYNC_STAGES        2
`endif

/* File: src/highv_pkg.sv */
package highv_pkg;
  typedef logic [1:0]  pin_vec_t;
  typedef logic [15:0] addr_t;
  typedef logic [7:0]  data_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_INPUT_STATE,
    SEL_PULL_SELECT,
    SEL_EDGE_POLARITY,
    SEL_CONV_BYPASS,
    SEL_DIRECT_CONNECT,
    SEL_EVENT_STATUS,
    SEL_EVENT_MASK
  } reg_sel_e;
endpackage

/* File: src/highv_sync_if.sv */
`timescale 1ns/100ps
interface highv_sync_if;
  highv_pkg::pin_vec_t pinRaw;
  highv_pkg::pin_vec_t polarity;
  highv_pkg::pin_vec_t pinSync;
  highv_pkg::pin_vec_t edgeEvent;

  modport owner (output pinRaw, output polarity,
                 input pinSync, input edgeEvent);
  modport sync  (input pinRaw, input polarity,
                 output pinSync, output edgeEvent);
endinterface

/* File: src/highv_pin_sync.sv */
`timescale 1ns/100ps
`include "highv_regs.svh"
module highv_pin_sync (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  highv_sync_if.sync port
);
  highv_pkg::pin_vec_t stage1;
  highv_pkg::pin_vec_t stage2;
  highv_pkg::pin_vec_t history;

  // ------------------------------------------------------------
  // Two-stage synchroniser, then one history stage
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i]  <= 1'b0;
          stage2[i]  <= 1'b0;
          history[i] <= 1'b0;
        end else begin
          stage1[i]  <= port.pinRaw[i];
          stage2[i]  <= stage1[i];
          history[i] <= stage2[i];
        end
      end
      // Rising when polarity is one, falling otherwise
      assign port.edgeEvent[i] = port.polarity[i] ?
                                 (stage2[i] & ~history[i]) :
                                 (~stage2[i] & history[i]);
    end
  endgenerate

  assign port.pinSync = stage2;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_syncDelay;
    @(posedge clk_sys) disable iff (!rst_n)
      ##2 port.pinSync == $past(port.pinRaw, 2);
  endproperty
  a_syncDelay: assert property (p_syncDelay)
    else $error("pin level not delayed by two stages");
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
`include "highv_regs.svh"
module tb;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic                clk_sys;
  logic                rst_n;
  highv_pkg::addr_t    addr;
  highv_pkg::data_t    wrData;
  logic                wrEn;
  logic                rdEn;
  highv_pkg::data_t    rdData;
  highv_pkg::pin_vec_t pin;
  highv_pkg::pin_vec_t dien;
  highv_pkg::pin_vec_t aen;
  highv_pkg::pin_vec_t test;
  logic                stopMode;
  highv_pkg::pin_vec_t padBuf;
  highv_pkg::pin_vec_t padUp;
  highv_pkg::pin_vec_t padDown;
  highv_pkg::pin_vec_t padDiv;
  highv_pkg::pin_vec_t padDirect;
  highv_pkg::pin_vec_t padBypass;
  logic                irq;
  highv_pkg::pin_vec_t eUp;
  highv_pkg::pin_vec_t eBuf;
  highv_pkg::pin_vec_t eDig;
  int                  n_errors;
  int                  checks;
  int                  cycles = 0;

  // Pull and direct settings differ per pin so one pin guards the other
  localparam highv_pkg::pin_vec_t CFG_PULL   = 2'b01;
  localparam highv_pkg::pin_vec_t CFG_DIRECT = 2'b10;
  localparam highv_pkg::pin_vec_t CFG_BYPASS = 2'b11;
  localparam highv_pkg::addr_t    UNMAPPED   = 16'h0335;

  highv_pkg::addr_t rwRegs [6] = '{`HIGHV_OFS_PULL_SELECT,
    `HIGHV_OFS_EDGE_POLARITY, `HIGHV_OFS_CONV_BYPASS,
    `HIGHV_OFS_DIRECT_CONNECT, `HIGHV_OFS_EVENT_STATUS,
    `HIGHV_OFS_EVENT_MASK};

  highv_input_port_control DUT (
    .clk_sys                    (clk_sys),
    .rst_n                      (rst_n),
    .addr                       (addr),
    .wrData                     (wrData),
    .wrEn                       (wrEn),
    .rdEn                       (rdEn),
    .rdData                     (rdData),
    .high_voltage_input_pin     (pin),
    .highv_digital_input_enable (dien),
    .highv_adc_connect_enable   (aen),
    .highv_test_enable          (test),
    .stopMode                   (stopMode),
    .inputBufferEnable          (padBuf),
    .pullupEnable               (padUp),
    .pulldownEnable             (padDown),
    .dividerActive              (padDiv),
    .adcDirectPath              (padDirect),
    .converterBypass            (padBypass),
    .irq                        (irq)
  );

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input highv_pkg::data_t got,
                          input highv_pkg::data_t exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pins(input highv_pkg::pin_vec_t got,
                          input highv_pkg::pin_vec_t exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input highv_pkg::addr_t a, input highv_pkg::data_t d);
    @(posedge clk_sys);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk_sys);
    wrEn   <= 1'b0;
  endtask

  task automatic rd(input highv_pkg::addr_t a, input highv_pkg::data_t exp,
                    input string what);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1;
    chk_byte(rdData, exp, what);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic drive(input highv_pkg::pin_vec_t p, de, ae, te,
                       input logic st);
    @(posedge clk_sys);
    pin      <= p;
    dien     <= de;
    aen      <= ae;
    test     <= te;
    stopMode <= st;
  endtask

  // Digital mode, enough wait for sync plus event latch
  task automatic ev_pin(input highv_pkg::pin_vec_t p);
    drive(p, 2'b11, 2'b00, 2'b00, 1'b0);
    settle(5);
  endtask

  // ----------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 16'h0000;
    wrData = 8'h00;
    wrEn = 1'b0;
    rdEn = 1'b0;
    pin = 2'h0;
    dien = 2'h0;
    aen = 2'h0;
    test = 2'h0;
    stopMode = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rwRegs[i]) rd(rwRegs[i], 8'h00, "reset value");
    rd(UNMAPPED, 8'h00, "unmapped read");
    wr(UNMAPPED, 8'hFF);
    wr(`HIGHV_OFS_PULL_SELECT, 8'hFC | 8'(CFG_PULL));
    wr(`HIGHV_OFS_DIRECT_CONNECT, 8'hFC | 8'(CFG_DIRECT));
    wr(`HIGHV_OFS_CONV_BYPASS, 8'hFC | 8'(CFG_BYPASS));
    rd(`HIGHV_OFS_PULL_SELECT, 8'(CFG_PULL), "pull rw");
    rd(`HIGHV_OFS_DIRECT_CONNECT, 8'(CFG_DIRECT), "direct rw");
    rd(`HIGHV_OFS_CONV_BYPASS, 8'(CFG_BYPASS), "bypass rw");
    rd(`HIGHV_OFS_EVENT_MASK, 8'h00, "mask after unmapped write");
    // Readback of synchronized pins across every digital-enable and ADC-enable setting
    for (int k = 0; k < 64; k++) begin
      drive(k[1:0], k[3:2], k[5:4], 2'b00, 1'b0);
      settle(3);
      eDig = dien & ~aen;
      rd(`HIGHV_OFS_INPUT_STATE, {6'h00, (eDig & pin) | ~eDig},
         "input state");
      if (k == 12) begin
        wr(`HIGHV_OFS_INPUT_STATE, 8'hFF);
        rd(`HIGHV_OFS_INPUT_STATE, 8'h00, "state after write");
        rd(`HIGHV_OFS_PULL_SELECT, 8'(CFG_PULL),
           "state write leak");
      end
    end
    // Pad controls across qualifiers and stop mode
    for (int k = 0; k < 128; k++) begin
      drive(2'b00, k[1:0], k[3:2], k[5:4], k[6]);
      settle(2);
      eUp = aen & CFG_PULL & test & {2{~stopMode}};
      eBuf = stopMode ? dien : ((aen & test & ~CFG_DIRECT) | (~aen & dien));
      chk_pins(padUp, eUp, "pullup");
      chk_pins(padDown, aen & ~eUp, "pulldown");
      chk_pins(padBuf, eBuf, "buffer");
      chk_pins(padDiv, aen & ~CFG_DIRECT, "divider");
      chk_pins(padDirect, aen & CFG_DIRECT, "direct");
      chk_pins(padBypass, aen & CFG_DIRECT & CFG_BYPASS,
               "bypass");
    end
    // Bypass bit clear keeps the converter in use on the direct pin
    wr(`HIGHV_OFS_CONV_BYPASS, 8'h00);
    drive(2'b00, 2'b00, 2'b11, 2'b00, 1'b0);
    settle(2);
    chk_pins(padBypass, 2'b00, "bypass off");
    // Events: pin0 on rising edges, pin1 on falling edges
    ev_pin(2'b00);
    wr(`HIGHV_OFS_EDGE_POLARITY, 8'hA9);
    rd(`HIGHV_OFS_EDGE_POLARITY, 8'h01, "polarity rw");
    wr(`HIGHV_OFS_EVENT_STATUS, 8'h03);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h00, "status cleared");
    ev_pin(2'b01);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h01, "pin0 rising");
    chk_pins({1'b0, irq}, 2'b00, "irq masked");
    wr(`HIGHV_OFS_EVENT_MASK, 8'h01);
    settle(2);
    chk_pins({1'b0, irq}, 2'b01, "irq unmasked");
    wr(`HIGHV_OFS_EVENT_STATUS, 8'h01);
    settle(2);
    chk_pins({1'b0, irq}, 2'b00, "irq cleared");
    ev_pin(2'b11);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h00, "pin1 rising ignored");
    ev_pin(2'b10);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h00, "pin0 falling ignored");
    ev_pin(2'b00);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h02, "pin1 falling");
    chk_pins({1'b0, irq}, 2'b00, "irq other mask");
    wr(`HIGHV_OFS_EVENT_MASK, 8'h02);
    settle(2);
    chk_pins({1'b0, irq}, 2'b01, "irq pin1");
    wr(`HIGHV_OFS_EVENT_STATUS, 8'h03);
    // Analog mode must not raise events
    drive(2'b01, 2'b11, 2'b11, 2'b00, 1'b0);
    settle(4);
    drive(2'b10, 2'b11, 2'b11, 2'b00, 1'b0);
    settle(5);
    rd(`HIGHV_OFS_EVENT_STATUS, 8'h00, "analog no event");
    chk_pins({1'b0, irq}, 2'b00, "irq idle");
    close_out();
  end
endmodule
